// File: rtl/vaa_pkg.sv
// constants, codes and types shared by the vault atomic add and poison unit
package vaa_pkg;
  // request and memory widths
  localparam int ADDR_W   = 35;   // request address field width
  localparam int BLK_LSB  = 4;    // lowest address bit of a 16-byte block
  localparam int BLK_W    = ADDR_W - BLK_LSB;
  localparam int DATA_W   = 128;  // one 16-byte memory location
  localparam int LANE_W   = 64;   // one 8-byte memory operand
  localparam int IMM4_W   = 32;   // dual add immediate width
  localparam int IMM8_W   = 64;   // wide add immediate width
  localparam int CMD_W    = 7;
  localparam int ERR_W    = 7;
  localparam int REG_AW   = 4;
  localparam int REG_DW   = 32;

  // command codes of the two add families
  localparam logic [CMD_W-1:0] CMD_DUAL_ADD   = 7'h12;  // 0010010
  localparam logic [CMD_W-1:0] CMD_P_DUAL_ADD = 7'h22;  // 0100010
  localparam logic [CMD_W-1:0] CMD_WIDE_ADD   = 7'h13;  // 0010011
  localparam logic [CMD_W-1:0] CMD_P_WIDE_ADD = 7'h23;  // 0100011

  // response error status codes (values are a local convention)
  localparam logic [ERR_W-1:0] ERR_OK     = 7'h00;
  localparam logic [ERR_W-1:0] ERR_POISON = 7'h31;
  localparam logic [ERR_W-1:0] ERR_MUE    = 7'h3f;

  // register indices
  localparam logic [REG_AW-1:0] REG_CTRL   = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 4'h1;
  localparam logic [REG_AW-1:0] REG_MASK   = 4'h2;
  localparam logic [REG_AW-1:0] REG_STATE  = 4'h3;

  // event bit positions in status and mask
  localparam int EV_DONE   = 0;  // atomic write-back completed
  localparam int EV_POISON = 1;  // atomic skipped on poisoned operand
  localparam int EV_MUE    = 2;  // atomic skipped on uncorrectable error
  localparam int EV_PIGN   = 3;  // poison flag seen on an atomic, ignored
  localparam int EV_BADCMD = 4;  // command outside the add family dropped
  localparam int EV_W      = 5;

  // reset values
  localparam logic [REG_DW-1:0] CTRL_RST = 32'h0000_0001;  // bit0 accept enable
  localparam logic [EV_W-1:0]   MASK_RST = 5'h00;

  // sequencer states, one-hot
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_RD   = 6'b000010,
    S_RDW  = 6'b000100,
    S_WR   = 6'b001000,
    S_WRW  = 6'b010000,
    S_RSP  = 6'b100000
  } vaa_state_type;
endpackage : vaa_pkg

// File: rtl/vaa_alu_if.sv
// operand and result bundle between the sequencer and the adder
`timescale 1ns/1ps
interface vaa_alu_if;
  import vaa_pkg::*;
  logic              wide;     // single 16-byte add when high, dual 8-byte else
  logic [DATA_W-1:0] memOp;    // original memory operand
  logic [DATA_W-1:0] payload;  // immediate payload as received
  logic [DATA_W-1:0] result;   // value to write back
  modport unit (output wide, output memOp, output payload, input result);
  modport alu  (input wide, input memOp, input payload, output result);
endinterface : vaa_alu_if

// File: rtl/vaa_add_alu.sv
// adder for dual 8-byte and single 16-byte signed add immediate
`timescale 1ns/1ps
module vaa_add_alu (
  vaa_alu_if.alu bus
);
  import vaa_pkg::*;

  logic [LANE_W-1:0] immLo;   // extended immediate 1
  logic [LANE_W-1:0] immHi;   // extended immediate 2
  logic [DATA_W-1:0] immWide; // extended wide immediate

  // immediates are sign-extended so negative values subtract
  always_comb begin
    immLo   = {{(LANE_W-IMM4_W){bus.payload[IMM4_W-1]}}, bus.payload[IMM4_W-1:0]};
    immHi   = {{(LANE_W-IMM4_W){bus.payload[LANE_W+IMM4_W-1]}},
               bus.payload[LANE_W+IMM4_W-1:LANE_W]};
    immWide = {{(DATA_W-IMM8_W){bus.payload[IMM8_W-1]}}, bus.payload[IMM8_W-1:0]};
  end

  // sums keep only the operand width, so the carry out is dropped
  always_comb begin
    if (bus.wide) begin
      bus.result = bus.memOp + immWide;
    end else begin
      bus.result[LANE_W-1:0]      = bus.memOp[LANE_W-1:0] + immLo;
      bus.result[DATA_W-1:LANE_W] = bus.memOp[DATA_W-1:LANE_W] + immHi;
    end
  end
endmodule : vaa_add_alu

// File: rtl/vaa_atomic_unit.sv
// vault atomic add sequencer with poison and uncorrectable error reporting
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module vaa_atomic_unit
  import vaa_pkg::*;
#(
  parameter int TAG_W  = 11,  // request tag width
  parameter int GROUPS = 16   // 16-byte groups in one plain read report
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       srst,
  // atomic request
  input  wire logic                       reqValid,
  output logic                            reqReady,
  input  wire logic [vaa_pkg::CMD_W-1:0]  reqCmd,
  input  wire logic [vaa_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [TAG_W-1:0]           reqTag,
  input  wire logic [vaa_pkg::DATA_W-1:0] reqPayload,
  input  wire logic                       reqPoison,
  // dram read and write
  output logic                            memRdReq,
  output logic                            memWrReq,
  output logic [vaa_pkg::BLK_W-1:0]       memAddr,
  output logic [vaa_pkg::DATA_W-1:0]      memWrData,
  input  wire logic                       memRdValid,
  input  wire logic [vaa_pkg::DATA_W-1:0] memRdData,
  input  wire logic                       memRdPoison,
  input  wire logic                       memRdMue,
  input  wire logic                       memWrDone,
  output logic                            bankLock,
  // response
  output logic                            rspValid,
  output logic                            rspTagValid,
  output logic [TAG_W-1:0]                rspTag,
  output logic [vaa_pkg::ERR_W-1:0]       rspErrStat,
  output logic                            rspDataInvalid,
  output logic                            rspAtomicFlag,
  // plain read status report
  input  wire logic                       rptValid,
  input  wire logic [GROUPS-1:0]          rptPoison,
  input  wire logic [GROUPS-1:0]          rptMue,
  output logic                            rptOutValid,
  output logic [vaa_pkg::ERR_W-1:0]       rptErrStat,
  output logic                            rptDataInvalid,
  // register port
  input  wire logic [vaa_pkg::REG_AW-1:0] regAddr,
  input  wire logic [vaa_pkg::REG_DW-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic [vaa_pkg::REG_DW-1:0]      regRdata,
  output logic                            irq
);
  import vaa_pkg::*;

  // refuse widths that would leave the tag or the group flags empty
  if (TAG_W < 1 || GROUPS < 1) begin : g_bad_param
    $error("vaa_atomic_unit: TAG_W and GROUPS must be positive");
  end

  // status and error combining shared by atomics and plain reads
  function automatic logic [ERR_W:0] classify(input logic anyPoison, input logic anyMue);
    logic [ERR_W:0] r;
    r = {1'b0, ERR_OK};
    if (anyPoison) begin
      r = {anyMue, ERR_POISON};
    end else if (anyMue) begin
      r = {1'b1, ERR_MUE};
    end
    return r;
  endfunction : classify

  vaa_state_type     state;       // sequencer state
  vaa_state_type     next_state;  // sequencer next state
  logic              accept;      // request taken this cycle
  logic              cmdOk;       // command is one of the four adds
  logic [CMD_W-1:0]  curCmd;      // captured command
  logic [BLK_W-1:0]  curBlk;      // captured block address
  logic [TAG_W-1:0]  curTag;      // captured tag
  logic [DATA_W-1:0] curPay;      // captured immediate payload
  logic              curPosted;   // captured posted variant
  logic              curWide;     // captured wide add
  logic [DATA_W-1:0] opnd;        // original memory operand
  logic              hitPoison;   // operand held a poison code
  logic              hitMue;      // operand uncorrectable
  logic              errFlag;     // atomic ended with an error
  logic [ERR_W:0]    atomCls;     // {invalid, status} for the atomic
  logic [ERR_W:0]    rptCls;      // {invalid, status} for a read report
  logic              ctrlEn;      // software accept enable
  logic [EV_W-1:0]   status;      // sticky events
  logic [EV_W-1:0]   mask;        // interrupt mask
  logic [EV_W-1:0]   evSet;       // events this cycle

  vaa_alu_if aluBus ();

  // the adder takes the read data straight in the cycle they arrive; the
  // captured operand is only updated on that same edge, so using it would
  // write back a sum built on the previous request's operand
  assign aluBus.wide    = curWide;
  assign aluBus.memOp   = (state == S_RDW) ? memRdData : opnd;
  assign aluBus.payload = curPay;

  vaa_add_alu u_alu (
    .bus (aluBus.alu)
  );

  // only the four add codes are served; none of them carries the atomic flag
  always_comb begin
    unique case (reqCmd)
      CMD_DUAL_ADD, CMD_P_DUAL_ADD, CMD_WIDE_ADD, CMD_P_WIDE_ADD: cmdOk = 1'b1;
      default:                                                    cmdOk = 1'b0;
    endcase
  end

  assign accept  = reqValid && reqReady;
  assign errFlag = hitPoison || hitMue;
  assign atomCls = classify(hitPoison, hitMue);
  assign rptCls  = classify(|rptPoison, |rptMue);

  // sequencer: read, combine, write back, answer
  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE: if (accept && cmdOk) begin
        next_state = S_RD;
      end
      S_RD:   next_state = S_RDW;
      S_RDW:  if (memRdValid) begin
        // a poisoned or broken operand is never updated
        next_state = (memRdPoison || memRdMue) ? S_RSP : S_WR;
      end
      S_WR:   next_state = S_WRW;
      S_WRW:  if (memWrDone) begin
        next_state = S_RSP;
      end
      S_RSP:  next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // request capture; bits below the block are dropped on the way in
  always_ff @(posedge clock) begin
    if (srst) begin
      curCmd    <= '0;
      curBlk    <= '0;
      curTag    <= '0;
      curPay    <= '0;
      curPosted <= 1'b0;
      curWide   <= 1'b0;
    end else if (accept && cmdOk) begin
      curCmd    <= reqCmd;
      curBlk    <= reqAddr[ADDR_W-1:BLK_LSB];
      // both adds work on a whole block; address bit 3 is dropped with the
      // rest, and the dual add updates both 8-byte lanes
      curTag    <= reqTag;
      curPay    <= reqPayload;
      curPosted <= (reqCmd == CMD_P_DUAL_ADD) || (reqCmd == CMD_P_WIDE_ADD);
      curWide   <= (reqCmd == CMD_WIDE_ADD) || (reqCmd == CMD_P_WIDE_ADD);
    end
  end

  // operand and error capture from the block read
  always_ff @(posedge clock) begin
    if (srst) begin
      opnd      <= '0;
      hitPoison <= 1'b0;
      hitMue    <= 1'b0;
    end else if (state == S_RDW && memRdValid) begin
      opnd      <= memRdData;
      hitPoison <= memRdPoison;
      hitMue    <= memRdMue && !memRdPoison;
    end
  end

  // request ready and bank lock follow the next state, so a new request
  // to this bank waits until the write-back is acknowledged
  always_ff @(posedge clock) begin
    if (srst) begin
      reqReady <= 1'b0;
      bankLock <= 1'b0;
    end else begin
      reqReady <= (next_state == S_IDLE) && ctrlEn;
      bankLock <= (next_state != S_IDLE);
    end
  end

  // memory strobes, one cycle each
  always_ff @(posedge clock) begin
    if (srst) begin
      memRdReq  <= 1'b0;
      memWrReq  <= 1'b0;
      memAddr   <= '0;
      memWrData <= '0;
    end else begin
      memRdReq <= (next_state == S_RD);
      memWrReq <= (next_state == S_WR);
      if (next_state == S_RD) begin
        memAddr <= (state == S_IDLE) ? reqAddr[ADDR_W-1:BLK_LSB] : curBlk;
      end
      if (next_state == S_WR) begin
        memWrData <= aluBus.result;
      end
    end
  end

  // response: status and tag only, the sum is never sent back
  always_ff @(posedge clock) begin
    if (srst) begin
      rspValid       <= 1'b0;
      rspTagValid    <= 1'b0;
      rspTag         <= '0;
      rspErrStat     <= ERR_OK;
      rspDataInvalid <= 1'b0;
      rspAtomicFlag  <= 1'b0;
    end else begin
      // posted adds answer only when something went wrong
      rspValid      <= (state == S_RSP) && (!curPosted || errFlag);
      rspAtomicFlag <= 1'b0;
      if (state == S_RSP) begin
        rspTagValid    <= !curPosted;
        rspTag         <= curPosted ? '0 : curTag;
        rspErrStat     <= atomCls[ERR_W-1:0];
        rspDataInvalid <= atomCls[ERR_W];
      end
    end
  end

  // plain read report classifier, one cycle of latency
  always_ff @(posedge clock) begin
    if (srst) begin
      rptOutValid    <= 1'b0;
      rptErrStat     <= ERR_OK;
      rptDataInvalid <= 1'b0;
    end else begin
      rptOutValid <= rptValid;
      if (rptValid) begin
        rptErrStat     <= rptCls[ERR_W-1:0];
        rptDataInvalid <= rptCls[ERR_W];
      end
    end
  end

  // events; the poison flag on a request only shows here, it never
  // changes how the add runs
  always_comb begin
    evSet            = '0;
    evSet[EV_DONE]   = (state == S_WRW) && memWrDone;
    evSet[EV_POISON] = (state == S_RDW) && memRdValid && memRdPoison;
    evSet[EV_MUE]    = (state == S_RDW) && memRdValid && memRdMue && !memRdPoison;
    evSet[EV_PIGN]   = accept && cmdOk && reqPoison;
    evSet[EV_BADCMD] = accept && !cmdOk;
  end

  // control, mask and sticky status; a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrlEn <= CTRL_RST[0];
      mask   <= MASK_RST;
      status <= '0;
    end else begin
      if (regWr && regAddr == REG_CTRL) begin
        ctrlEn <= regWdata[0];
      end
      if (regWr && regAddr == REG_MASK) begin
        mask <= regWdata[EV_W-1:0];
      end
      if (regWr && regAddr == REG_STATUS) begin
        status <= (status & ~regWdata[EV_W-1:0]) | evSet;
      end else begin
        status <= status | evSet;
      end
    end
  end

  // read data one cycle after the strobe, zero for unmapped indices
  always_ff @(posedge clock) begin
    if (srst) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        REG_CTRL:   regRdata <= {{(REG_DW-1){1'b0}}, ctrlEn};
        REG_STATUS: regRdata <= {{(REG_DW-EV_W){1'b0}}, status};
        REG_MASK:   regRdata <= {{(REG_DW-EV_W){1'b0}}, mask};
        REG_STATE:  regRdata <= {{(REG_DW-6){1'b0}}, state};
        default:    regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // level interrupt
  always_ff @(posedge clock) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_poison_clean;
    (state == S_RDW) && memRdValid && memRdPoison && !curPosted
      |-> ##2 rspValid && rspErrStat == ERR_POISON && !rspDataInvalid;
  endproperty
  a_poison_clean: assert property (p_poison_clean) else $error("poison answer wrong");

  property p_rpt_poison_only;
    rptValid && (|rptPoison) && !(|rptMue)
      |=> rptOutValid && rptErrStat == ERR_POISON && !rptDataInvalid;
  endproperty
  a_rpt_poison_only: assert property (p_rpt_poison_only) else $error("corrected poison misreported");

  property p_rpt_poison_mue;
    rptValid && (|rptPoison) && (|rptMue) |=> rptErrStat == ERR_POISON && rptDataInvalid;
  endproperty
  a_rpt_poison_mue: assert property (p_rpt_poison_mue) else $error("poison with mue lacks invalid");

  property p_mue_only;
    (state == S_RDW) && memRdValid && memRdMue && !memRdPoison && !curPosted
      |-> ##2 rspValid && rspErrStat == ERR_MUE && rspDataInvalid;
  endproperty
  a_mue_only: assert property (p_mue_only) else $error("mue answer wrong");

  property p_poison_skip;
    (state == S_RDW) && memRdValid && memRdPoison |=> !memWrReq [*3];
  endproperty
  a_poison_skip: assert property (p_poison_skip) else $error("poisoned operand written");

  property p_hold_bank;
    (state == S_WRW) && !memWrDone |=> bankLock && !reqReady;
  endproperty
  a_hold_bank: assert property (p_hold_bank) else $error("bank released early");

  property p_block_addr;
    accept && cmdOk |=> memRdReq && memAddr == $past(reqAddr[ADDR_W-1:BLK_LSB]);
  endproperty
  a_block_addr: assert property (p_block_addr) else $error("block address wrong");

  property p_dual_sum;
    memWrReq && !curWide |-> memWrData[LANE_W-1:0] ==
      opnd[LANE_W-1:0] + {{(LANE_W-IMM4_W){curPay[IMM4_W-1]}}, curPay[IMM4_W-1:0]};
  endproperty
  a_dual_sum: assert property (p_dual_sum) else $error("dual add low lane wrong");

  property p_wide_sum;
    memWrReq && curWide |-> memWrData ==
      opnd + {{(DATA_W-IMM8_W){curPay[IMM8_W-1]}}, curPay[IMM8_W-1:0]};
  endproperty
  a_wide_sum: assert property (p_wide_sum) else $error("wide add wrong");

  property p_posted_silent;
    (state == S_RSP) && curPosted && !errFlag |=> !rspValid;
  endproperty
  a_posted_silent: assert property (p_posted_silent) else $error("posted add answered");

  property p_no_flag;
    rspValid |-> !rspAtomicFlag && (rspTagValid == !curPosted);
  endproperty
  a_no_flag: assert property (p_no_flag) else $error("flag or tag wrong");

  c_poison_skip: cover property ((state == S_RDW) && memRdValid && memRdPoison);
  c_posted_error: cover property (rspValid && !rspTagValid);
  c_dual_write: cover property (memWrReq && !curWide);
  c_wide_write: cover property (memWrReq && curWide);
endmodule : vaa_atomic_unit

// File: dv/vaa_mem_model.sv
// far-side dram model: reads and writes answered after a set latency
`timescale 1ns/1ps
module vaa_mem_model
  import vaa_pkg::*;
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       srst,
  // requests from the unit
  input  wire logic                       memRdReq,
  input  wire logic                       memWrReq,
  input  wire logic [vaa_pkg::BLK_W-1:0]  memAddr,
  input  wire logic [vaa_pkg::DATA_W-1:0] memWrData,
  // bench controls
  input  wire logic [3:0]                 lat,
  input  wire logic                       injPoison,
  input  wire logic                       injMue,
  // answers
  output logic                            memRdValid,
  output logic [vaa_pkg::DATA_W-1:0]      memRdData,
  output logic                            memRdPoison,
  output logic                            memRdMue,
  output logic                            memWrDone
);
  logic [DATA_W-1:0] store [16];  // low block bits pick one of sixteen
  logic [4:0]        rdCnt;       // cycles left until read data
  logic [4:0]        wrCnt;       // cycles left until write done
  logic [3:0]        rdIdx;       // block being read
  // read side: outside the valid cycle the lines toggle, so stale data never looks good
  always @(posedge clock) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    memRdPoison <= ~memRdPoison;
    memRdMue <= ~memRdMue;
    if (srst) begin
      rdCnt <= '0;
      memRdData <= '0;
      memRdPoison <= 1'b0;
      memRdMue <= 1'b0;
    end else if (memRdReq) begin
      rdIdx <= memAddr[3:0];
      rdCnt <= lat + 5'h1;
    end else if (rdCnt == 5'h1) begin
      memRdValid <= 1'b1;
      memRdData <= store[rdIdx];
      memRdPoison <= injPoison;
      memRdMue <= injMue;
      rdCnt <= '0;
    end else if (rdCnt != '0) begin
      rdCnt <= rdCnt - 5'h1;
    end
  end
  // write side: store at once, report done after the latency
  always @(posedge clock) begin
    memWrDone <= 1'b0;
    if (srst) begin
      wrCnt <= '0;
    end else if (memWrReq) begin
      store[memAddr[3:0]] <= memWrData;
      wrCnt <= lat + 5'h1;
    end else if (wrCnt == 5'h1) begin
      memWrDone <= 1'b1;
      wrCnt <= '0;
    end else if (wrCnt != '0) begin
      wrCnt <= wrCnt - 5'h1;
    end
  end
endmodule : vaa_mem_model

// File: dv/vault_atomic_add_poison_unit_bench.sv
// self-checking bench for the vault atomic add and poison unit
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module vault_atomic_add_poison_unit_bench;
  import vaa_pkg::*;
  // stimulus
  logic              clock = 1'b0, srst = 1'b1, reqValid = 1'b0, reqPoison = 1'b0, injPoison = 1'b0;
  logic              regWr = 1'b0, regRd = 1'b0, rptValid = 1'b0, injMue = 1'b0, rdPend = 1'b0;
  logic [CMD_W-1:0]  reqCmd = '0;
  logic [ADDR_W-1:0] reqAddr = '0;
  logic [10:0]       reqTag = '0, rspTag;
  logic [DATA_W-1:0] reqPayload = '0, memWrData, memRdData, r;
  logic [15:0]       rptPoison = '0, rptMue = '0, seed = 16'h2f56;  // seed 12118
  logic [REG_AW-1:0] regAddr = '0;
  logic [REG_DW-1:0] regWdata = '0, regRdata;
  logic [3:0]        lat = '0;
  // observed
  logic              reqReady, memRdReq, memWrReq, memRdValid, memRdPoison, memRdMue, memWrDone, bankLock;
  logic              rspValid, rspTagValid, rspDataInvalid, rspAtomicFlag, rptOutValid, rptDataInvalid, irq;
  logic [BLK_W-1:0]  memAddr;
  logic [ERR_W-1:0]  rspErrStat, rptErrStat;
  logic [EV_W-1:0]   expStat = '0;  // status bits the traffic should have set
  logic [160:0]      q[$];          // expected events, oldest first
  logic [160:0]      nx;            // oldest note, taken once per result
  int                n_fail = 0, total_checks = 0;
  wire logic [20:0]  rspBits = {rspTagValid, rspTag, rspErrStat, rspDataInvalid, rspAtomicFlag};
  localparam logic [CMD_W-1:0] CMDS [4] = '{CMD_DUAL_ADD, CMD_P_DUAL_ADD, CMD_WIDE_ADD, CMD_P_WIDE_ADD};

  vaa_atomic_unit #(.TAG_W(11), .GROUPS(16)) uut (
    .clock(clock), .srst(srst), .reqValid(reqValid), .reqReady(reqReady), .reqCmd(reqCmd), .reqAddr(reqAddr),
    .reqTag(reqTag), .reqPayload(reqPayload), .reqPoison(reqPoison), .memRdReq(memRdReq), .memWrReq(memWrReq),
    .memAddr(memAddr), .memWrData(memWrData), .memRdValid(memRdValid), .memRdData(memRdData),
    .memRdPoison(memRdPoison), .memRdMue(memRdMue), .memWrDone(memWrDone), .bankLock(bankLock),
    .rspValid(rspValid), .rspTagValid(rspTagValid), .rspTag(rspTag), .rspErrStat(rspErrStat),
    .rspDataInvalid(rspDataInvalid), .rspAtomicFlag(rspAtomicFlag), .rptValid(rptValid), .rptPoison(rptPoison),
    .rptMue(rptMue), .rptOutValid(rptOutValid), .rptErrStat(rptErrStat), .rptDataInvalid(rptDataInvalid),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq)
  );
  vaa_mem_model mem (
    .clock(clock), .srst(srst), .memRdReq(memRdReq), .memWrReq(memWrReq), .memAddr(memAddr),
    .memWrData(memWrData), .lat(lat), .injPoison(injPoison), .injMue(injMue), .memRdValid(memRdValid),
    .memRdData(memRdData), .memRdPoison(memRdPoison), .memRdMue(memRdMue), .memWrDone(memWrDone)
  );

  always #12.5 clock = ~clock;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic rnd(output logic [127:0] v);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = {v[111:0], seed};
    end
  endtask : rnd
  // an empty queue yields unknown, which never matches
  function automatic logic [160:0] pop();
    return (q.size() > 0) ? q.pop_front() : 'x;
  endfunction : pop

  // watcher: each result takes the oldest note
  always @(posedge clock) begin
    rdPend <= regRd;
    // the note is popped once, so a mismatch report cannot eat the next note
    if (rdPend) begin
      nx = pop();
      `CHK({2'h3, 127'h0, regRdata}, nx)
    end
    if (memWrReq === 1'b1) begin
      nx = pop();
      `CHK({2'h0, memAddr, memWrData}, nx)
    end
    if (memWrReq === 1'b1) `CHK(bankLock, 1'b1)
    if (rspValid === 1'b1) begin
      nx = pop();
      `CHK({2'h1, 138'h0, rspBits}, nx)
    end
    if (rptOutValid === 1'b1) begin
      nx = pop();
      `CHK({2'h2, 151'h0, rptErrStat, rptDataInvalid}, nx)
    end
  end

  // bounded wait for the unit to take a request
  task automatic wrdy();
    int k;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (reqReady !== 1'b1 && k < 100);
    if (k >= 100) `CHK(1'b0, 1'b1)
  endtask : wrdy
  task automatic regW(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clock);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask : regW
  task automatic regR(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
    q.push_back({2'h3, 127'h0, e});
    @(posedge clock);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
  endtask : regR
  // one atomic request; mp and mm make the read come back poisoned or uncorrectable
  task automatic atomic(input logic [CMD_W-1:0] c, input logic mp, input logic mm, input logic rp);
    logic [127:0] m, p, w;
    logic [ERR_W-1:0] e;
    logic ok, pst;
    rnd(m);
    rnd(p);
    rnd(r);
    ok = c inside {CMDS};
    pst = c inside {CMD_P_DUAL_ADD, CMD_P_WIDE_ADD};
    if (c[0]) p[127:64] = {64{p[63]}};  // wide immediate is the low 8 bytes, the upper 8 hold its sign
    else p = {32'h0, p[95:64], 32'h0, p[31:0]};
    w = c[0] ? m + {{64{p[63]}}, p[63:0]} :
        {m[127:64] + {{32{p[95]}}, p[95:64]}, m[63:0] + {{32{p[31]}}, p[31:0]}};
    e = mp ? ERR_POISON : mm ? ERR_MUE : ERR_OK;
    mem.store[r[7:4]] = m;
    if (ok && !mp && !mm) q.push_back({2'h0, r[34:4], w});
    if (ok && (mp || mm || !pst)) q.push_back({2'h1, 138'h0, !pst, pst ? 11'h0 : r[51:41], e, mm && !mp, 1'b0});
    expStat = expStat | {!ok, rp & ok, mm & !mp & ok, mp & ok, ok & !mp & !mm};
    injPoison <= mp;
    injMue <= mm;
    @(posedge clock);
    reqValid <= 1'b1;
    reqCmd <= c;
    reqAddr <= r[34:0];
    reqTag <= r[51:41];
    reqPayload <= p;
    reqPoison <= rp;
    lat <= r[55:52];
    wrdy();
    reqValid <= 1'b0;
    repeat (2) @(posedge clock);
    wrdy();
  endtask : atomic
  task automatic rpt(input logic [15:0] pz, input logic [15:0] mu);
    q.push_back({2'h2, 151'h0, (pz != 0) ? ERR_POISON : (mu != 0) ? ERR_MUE : ERR_OK, |mu});
    @(posedge clock);
    rptValid <= 1'b1;
    rptPoison <= pz;
    rptMue <= mu;
    @(posedge clock);
    rptValid <= 1'b0;
  endtask : rpt
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    regR(REG_CTRL, CTRL_RST);
    regR(REG_STATUS, 32'h0);
    regR(REG_MASK, 32'h0);
    regR(REG_STATE, 32'h1);
    regR(4'h9, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 12; i++) atomic(CMDS[i % 4], 1'b0, 1'b0, i[2]);
    $display("test add commands done");
    for (int i = 0; i < 12; i++) atomic(CMDS[i % 4], i / 4 != 1, i / 4 != 0, 1'b0);
    atomic(7'h52, 1'b0, 1'b0, 1'b0);  // outside the add family: dropped
    $display("test faults done");
    regR(REG_STATUS, 32'(expStat));
    `CHK(irq, 1'b0)
    regW(REG_MASK, 32'h4);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b1)
    regW(REG_STATUS, 32'(expStat));
    regR(REG_STATUS, 32'h0);
    repeat (3) @(posedge clock);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    for (int i = 0; i < 8; i++) begin
      rnd(r);
      rpt(i[0] ? r[15:0] | 16'h1 : 16'h0, i[1] ? r[31:16] | 16'h8000 : 16'h0);
    end
    repeat (5) @(posedge clock);
    `CHK(q.size(), 0)
    $display("test reports done");
    conclude();
  end

  // watchdog sized well past the expected run
  initial begin
    #(25 * 20000);
    n_fail++;
    conclude();
  end
endmodule : vault_atomic_add_poison_unit_bench
